/* hdl/pcc_defs.svh */
// constants for the pulse counter core: reset values, fail mode codes, timing
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// configuration reset values and the timebase minimum
`define PCC_EN_RST        1'b0
`define PCC_DIR_RST       1'b0
`define PCC_SHOT_RST      1'b0
`define PCC_FILT_RST      1'b0
`define PCC_STROBE_RST    1'b0
`define PCC_FAIL_RST      2'h0
`define PCC_TB_RST        16'h03e8
`define PCC_TB_MIN        16'h000a
`define PCC_HI_LIM_RST    16'h7fff
`define PCC_LO_LIM_RST    16'h0000
`define PCC_ON_PST_RST    16'h7fff
`define PCC_OFF_PST_RST   16'h0000
`define PCC_PRELOAD_RST   16'h0000

// fail mode codes
`define PCC_FAIL_NORMAL   2'h0
`define PCC_FAIL_LOW      2'h1
`define PCC_FAIL_HOLD     2'h2

// timing in nanoseconds and derived cycle counts
`define PCC_CLK_NS        20
`define PCC_CMP_NS        500000
`define PCC_MS_NS         1000000
`define PCC_HF_NS         2000
`define PCC_LF_NS         1000000
`define PCC_CMP_CYC       (`PCC_CMP_NS / `PCC_CLK_NS)
`define PCC_MS_CYC        (`PCC_MS_NS / `PCC_CLK_NS)
`define PCC_HF_CYC        (`PCC_HF_NS / `PCC_CLK_NS)
`define PCC_LF_CYC        (`PCC_LF_NS / `PCC_CLK_NS)

`endif

/* hdl/pcc_pkg.sv */
// types shared by the pulse counter core modules
package pcc_pkg;
	// signed accumulator word
	typedef logic signed [15:0] pcc_cnt_t;
	// behaviour of the output while the host is stopped
	typedef enum logic [1:0] {
		fail_normal    = 2'b00,
		fail_force_low = 2'b01,
		fail_hold      = 2'b10
	} pcc_fail_t;
endpackage : pcc_pkg

/* hdl/pcc_sig_if.sv */
// filtered input level and its rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
interface pcc_sig_if;
	logic level; // filtered level
	logic rise;  // one-cycle pulse on a filtered rising edge
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface : pcc_sig_if
`default_nettype wire

/* hdl/pcc_filt.sv */
// selectable stability filter with rising-edge detection
`timescale 1ns/1ns
`default_nettype none
module pcc_filt #(
	parameter int HF_CYC = 100,
	parameter int LF_CYC = 50000,
	parameter int CW     = 16
) (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst,
	// raw input and filter choice
	input  wire logic   raw,
	input  wire logic   sel_low,
	// filtered output
	pcc_sig_if.src      sig
);
	localparam logic [CW-1:0] HF_L = CW'(HF_CYC - 1); // fast settle count
	localparam logic [CW-1:0] LF_L = CW'(LF_CYC - 1); // slow settle count

	logic [CW-1:0] cnt;   // cycles the raw input has differed
	logic [CW-1:0] lim;   // settle count in use

	assign lim = sel_low ? LF_L : HF_L;

	// accept a new level only after it stood for the whole settle time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt       <= '0;
			sig.level <= 1'b0;
			sig.rise  <= 1'b0;
		end else begin
			sig.rise <= 1'b0;
			if (raw == sig.level) begin
				cnt <= '0;
			end else if (cnt >= lim) begin
				cnt       <= '0;
				sig.level <= raw;
				sig.rise  <= raw;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule : pcc_filt
`default_nettype wire

/* hdl/pcc_top.sv */
// pulse counter core: accumulator, limits, rate, preset output, fail mode
// Notes on behaviour
// [R1] counter starts disabled until configuration enables it
// [R2] filters default fast; strobe use forces fast
// [R3] one counter, direction up or down, up default
// [R4] continuous mode wraps to the opposite limit
// [R5] single shot stops at limit, reversal leaves it
// [R6] timebase 10 to 65535 ms, default 1000
// [R7] rate register captures interval count, wraps silently
// [R8] signed limits, high above low, defaults given
// [R9] new limits force stray accumulator to low
// [R10] bad limit pair rejected, error flag raised
// [R11] host orders single limit changes to stay valid
// [R12] between presets output takes lower preset state
// [R13] outside presets output takes upper preset state
// [R14] limits replace missing preset, wrap toggles output
// [R15] no preset in range: output fixed constant
// [R16] equal presets: off outside, one value inside
// [R17] presets compared every half millisecond
// [R18] preload input loads signed preload value
// [R19] above high limit: overflow unless down counts
// [R20] below low limit: down count underflows at once
// [R21] stopped host: normal, forced low or hold
// [R22] fail behaviour lasts while host stays stopped
// [R23] fast filter passes counts up to 10 kHz
// [R24] disabled counter ignores inputs, output low
`include "pcc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pcc_top #(
	parameter int CMP_CYC = `PCC_CMP_CYC,
	parameter int MS_CYC  = `PCC_MS_CYC,
	parameter int HF_CYC  = `PCC_HF_CYC,
	parameter int LF_CYC  = `PCC_LF_CYC
) (
	// clock and reset
	input  wire logic               SYS_CLK,
	input  wire logic               RST,
	// field inputs
	input  wire logic               CNT_IN,
	input  wire logic               PLD_IN,
	// host state
	input  wire logic               CPU_RUN,
	// general configuration, taken on CFG_WR
	input  wire logic               CFG_WR,
	input  wire logic               CFG_EN,
	input  wire logic               CFG_DIR_DOWN,
	input  wire logic               CFG_ONE_SHOT,
	input  wire logic               CFG_CNT_FILT_LOW,
	input  wire logic               CFG_PLD_STROBE,
	input  wire logic               CFG_PLD_FILT_LOW,
	input  wire logic [1:0]         CFG_FAIL_MODE,
	input  wire logic [15:0]        CFG_TIMEBASE,
	input  wire logic [15:0]        CFG_ON_PST,
	input  wire logic [15:0]        CFG_OFF_PST,
	input  wire logic [15:0]        CFG_PRELOAD,
	// limit pair, taken on CFG_LIM_WR
	input  wire logic               CFG_LIM_WR,
	input  wire logic [15:0]        CFG_HI_LIM,
	input  wire logic [15:0]        CFG_LO_LIM,
	// status
	output var  pcc_pkg::pcc_cnt_t  ACC,
	output var  pcc_pkg::pcc_cnt_t  RATE,
	output var  pcc_pkg::pcc_cnt_t  STROBE_VAL,
	output logic                    OUT_Q,
	output logic                    ENABLED,
	output logic                    LIM_ERR
);
	localparam int CMPW = $clog2(CMP_CYC); // half-ms prescaler width
	localparam int MSW  = $clog2(MS_CYC);  // ms prescaler width

	// configuration state
	logic               dir_down;    // count direction
	logic               one_shot;    // stop at limits
	logic               cnt_low;     // slow filter on count input
	logic               pld_strobe;  // second input used as strobe
	logic               pld_low;     // slow filter wanted on second input
	pcc_pkg::pcc_fail_t fail_mode;   // output behaviour while host stopped
	logic [15:0]        tb_ms;       // timebase length in ms
	pcc_pkg::pcc_cnt_t  on_pst;      // on switching point
	pcc_pkg::pcc_cnt_t  off_pst;     // off switching point
	pcc_pkg::pcc_cnt_t  preload;     // value loaded by the preload input
	pcc_pkg::pcc_cnt_t  hi_lim;      // upper count limit
	pcc_pkg::pcc_cnt_t  lo_lim;      // lower count limit

	// timing state
	logic [CMPW-1:0]    cmp_pre;     // half-ms prescaler
	logic               cmp_tick;    // one cycle per half-ms period
	logic [MSW-1:0]     ms_pre;      // ms prescaler
	logic [15:0]        tb_cnt;      // ms elapsed in current interval
	logic               tb_end;      // last cycle of an interval
	logic               down_seen;   // a down count arrived this period
	pcc_pkg::pcc_cnt_t  rate_cnt;    // signed count of current interval

	// combinational helpers
	pcc_pkg::pcc_cnt_t  new_hi;      // offered high limit
	pcc_pkg::pcc_cnt_t  new_lo;      // offered low limit
	logic               lim_ok;      // accepted limit write
	logic               lim_fix;     // accepted and accumulator outside
	logic               cnt_ev;      // counted pulse
	logic               pld_ev;      // preload request
	logic               stb_ev;      // strobe capture request
	logic               ovf_chk;     // period-end overflow adjustment
	logic               next_out;    // compared output state
	pcc_pkg::pcc_cnt_t  next_acc;    // accumulator next value
	pcc_pkg::pcc_cnt_t  step;        // signed step of this cycle
	pcc_pkg::pcc_cnt_t  next_rate;   // interval count including this cycle
	logic [1:0]         raw_in;      // raw field inputs
	logic [1:0]         sel_low;     // filter choice per input

	// filtered inputs: index 0 count, index 1 preload or strobe
	pcc_sig_if sig [2] ();

	assign raw_in  = {PLD_IN, CNT_IN};
	assign sel_low = {pld_low & ~pld_strobe, cnt_low}; // R2

	// one filter per field input; fast setting settles well inside 50 us
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			pcc_filt #(
				.HF_CYC (HF_CYC),
				.LF_CYC (LF_CYC),
				.CW     (MSW + 1)
			) u_filt (
				.clk     (SYS_CLK),
				.rst     (RST),
				.raw     (raw_in[gi]),
				.sel_low (sel_low[gi]),
				.sig     (sig[gi])
			); // R23
		end
	endgenerate

	// output state for an accumulator value and the two presets
	function automatic logic cmp_out(
		input pcc_pkg::pcc_cnt_t a,
		input pcc_pkg::pcc_cnt_t on,
		input pcc_pkg::pcc_cnt_t off,
		input pcc_pkg::pcc_cnt_t hi,
		input pcc_pkg::pcc_cnt_t lo
	);
		logic              on_in;
		logic              off_in;
		logic              res;
		pcc_pkg::pcc_cnt_t on_c;
		pcc_pkg::pcc_cnt_t off_c;
		on_in  = (on >= lo) && (on <= hi);
		off_in = (off >= lo) && (off <= hi);
		on_c   = on_in ? on : ((on > hi) ? hi : lo); // R14
		off_c  = off_in ? off : ((off > hi) ? hi : lo); // R14
		res    = 1'b0;
		if (on == off) begin
			// single on value inside, never on outside
			res = on_in && (a == on); // R16
		end else if (!on_in && !off_in) begin
			// fixed at the upper preset's state
			res = (on > off); // R15
		end else if (on < off) begin
			// on inclusive from on point to off point
			res = (a >= on_c) && (a <= off_c); // R12 R13
		end else begin
			// off inclusive from off point to on point
			res = !((a >= off_c) && (a <= on_c)); // R12 R13
		end
		return res;
	endfunction : cmp_out

	// event decode; field events and overflow are ignored while disabled, limit writes are not
	always_comb begin
		new_hi  = pcc_pkg::pcc_cnt_t'(CFG_HI_LIM);
		new_lo  = pcc_pkg::pcc_cnt_t'(CFG_LO_LIM);
		lim_ok  = CFG_LIM_WR && (new_hi > new_lo); // R8 R10
		lim_fix = lim_ok && ((ACC > new_hi) || (ACC < new_lo)); // R9
		cnt_ev  = ENABLED && sig[0].rise; // R24
		pld_ev  = ENABLED && sig[1].rise && !pld_strobe; // R24
		stb_ev  = ENABLED && sig[1].rise && pld_strobe;
		ovf_chk = ENABLED && cmp_tick && (ACC > hi_lim) && !down_seen; // R19
		next_out = cmp_out(ACC, on_pst, off_pst, hi_lim, lo_lim);
	end

	// accumulator next value by priority: limits, preload, overflow, count
	always_comb begin
		next_acc = ACC;
		if (lim_fix) begin
			next_acc = new_lo; // R9
		end else if (pld_ev) begin
			next_acc = preload; // R18
		end else if (ovf_chk) begin
			next_acc = one_shot ? hi_lim : lo_lim; // R19
		end else if (cnt_ev && !dir_down) begin
			if (ACC > hi_lim) begin
				// held until the period ends without down counts
				next_acc = ACC; // R19
			end else if (ACC == hi_lim) begin
				next_acc = one_shot ? hi_lim : lo_lim; // R4 R5
			end else begin
				next_acc = ACC + 16'sh0001; // R3
			end
		end else if (cnt_ev) begin
			if (ACC <= lo_lim) begin
				// at or below low limit: underflow at once
				next_acc = one_shot ? lo_lim : hi_lim; // R4 R5 R20
			end else begin
				next_acc = ACC - 16'sh0001; // R3
			end
		end
	end

	// signed step for the rate count; wraps without saturation
	always_comb begin
		step = 16'sh0000;
		if (cnt_ev) begin
			step = dir_down ? -16'sh0001 : 16'sh0001;
		end
		next_rate = rate_cnt + step; // R7
	end

	// general configuration register
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ENABLED    <= `PCC_EN_RST; // R1
			dir_down   <= `PCC_DIR_RST; // R3
			one_shot   <= `PCC_SHOT_RST; // R4
			cnt_low    <= `PCC_FILT_RST; // R2
			pld_strobe <= `PCC_STROBE_RST;
			pld_low    <= `PCC_FILT_RST; // R2
			fail_mode  <= pcc_pkg::fail_normal; // R21
			tb_ms      <= `PCC_TB_RST; // R6
			on_pst     <= `PCC_ON_PST_RST;
			off_pst    <= `PCC_OFF_PST_RST;
			preload    <= `PCC_PRELOAD_RST; // R18
		end else if (CFG_WR) begin
			ENABLED    <= CFG_EN; // R1
			dir_down   <= CFG_DIR_DOWN; // R3
			one_shot   <= CFG_ONE_SHOT;
			cnt_low    <= CFG_CNT_FILT_LOW; // R2
			pld_strobe <= CFG_PLD_STROBE;
			pld_low    <= CFG_PLD_FILT_LOW; // R2
			// unused code falls back to normal operation
			unique case (CFG_FAIL_MODE)
				`PCC_FAIL_LOW:  fail_mode <= pcc_pkg::fail_force_low;
				`PCC_FAIL_HOLD: fail_mode <= pcc_pkg::fail_hold;
				default:        fail_mode <= pcc_pkg::fail_normal;
			endcase
			// short timebase values are raised to the floor
			tb_ms      <= (CFG_TIMEBASE < `PCC_TB_MIN) ?
				`PCC_TB_MIN : CFG_TIMEBASE; // R6
			on_pst     <= pcc_pkg::pcc_cnt_t'(CFG_ON_PST);
			off_pst    <= pcc_pkg::pcc_cnt_t'(CFG_OFF_PST);
			preload    <= pcc_pkg::pcc_cnt_t'(CFG_PRELOAD); // R18
		end
	end

	// limit pair and its error flag; a bad pair keeps the old limits
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			hi_lim  <= `PCC_HI_LIM_RST; // R8
			lo_lim  <= `PCC_LO_LIM_RST; // R8
			LIM_ERR <= 1'b0;
		end else if (CFG_LIM_WR) begin
			if (lim_ok) begin
				hi_lim  <= new_hi;
				lo_lim  <= new_lo;
				LIM_ERR <= 1'b0;
			end else begin
				LIM_ERR <= 1'b1; // R10
			end
		end
	end

	// half-millisecond compare period
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			cmp_pre  <= '0;
			cmp_tick <= 1'b0;
		end else if (cmp_pre == CMPW'(CMP_CYC - 1)) begin
			cmp_pre  <= '0;
			cmp_tick <= 1'b1; // R17
		end else begin
			cmp_pre  <= cmp_pre + 1'b1;
			cmp_tick <= 1'b0;
		end
	end

	// down counts seen in the running period; a new event wins the clear
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			down_seen <= 1'b0;
		end else begin
			down_seen <= (down_seen && !cmp_tick) ||
				(cnt_ev && dir_down); // R19
		end
	end

	// accumulator
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ACC <= `PCC_PRELOAD_RST;
		end else begin
			ACC <= next_acc;
		end
	end

	// strobe register captures the accumulator on the strobe input
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			STROBE_VAL <= 16'sh0000;
		end else if (stb_ev) begin
			STROBE_VAL <= ACC;
		end
	end

	// millisecond prescaler and timebase interval counter
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ms_pre <= '0;
			tb_cnt <= 16'h0000;
			tb_end <= 1'b0;
		end else if (!ENABLED) begin
			ms_pre <= '0;
			tb_cnt <= 16'h0000;
			tb_end <= 1'b0;
		end else if (ms_pre == MSW'(MS_CYC - 1)) begin
			ms_pre <= '0;
			if (tb_cnt >= tb_ms - 16'h0001) begin
				tb_cnt <= 16'h0000;
				tb_end <= 1'b1; // R6
			end else begin
				tb_cnt <= tb_cnt + 16'h0001;
				tb_end <= 1'b0;
			end
		end else begin
			ms_pre <= ms_pre + 1'b1;
			tb_end <= 1'b0;
		end
	end

	// rate count and rate register
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rate_cnt <= 16'sh0000;
			RATE     <= 16'sh0000;
		end else if (!ENABLED) begin
			rate_cnt <= 16'sh0000;
		end else if (tb_end) begin
			RATE     <= next_rate; // R7
			rate_cnt <= 16'sh0000;
		end else begin
			rate_cnt <= next_rate;
		end
	end

	// preset output with host fail handling
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			OUT_Q <= 1'b0;
		end else if (!ENABLED) begin
			OUT_Q <= 1'b0; // R24
		end else if (!CPU_RUN && fail_mode == pcc_pkg::fail_force_low) begin
			OUT_Q <= 1'b0; // R21 R22
		end else if (!CPU_RUN && fail_mode == pcc_pkg::fail_hold) begin
			OUT_Q <= OUT_Q; // R21 R22
		end else if (cmp_tick) begin
			OUT_Q <= next_out; // R17
		end
	end

	// checks on the logic above
	AST_EN_CFG: assert property (@(posedge SYS_CLK) disable iff (RST)
		$changed(ENABLED) |-> $past(CFG_WR)) // R1
		else $error("enable changed without a configuration write");
	AST_UP_STEP: assert property (@(posedge SYS_CLK) disable iff (RST)
		cnt_ev && !dir_down && !lim_fix && !pld_ev && !ovf_chk &&
		ACC < hi_lim && ACC >= lo_lim |=> ACC == $past(ACC) + 16'sh0001)
		else $error("up count did not add one"); // R3
	AST_WRAP: assert property (@(posedge SYS_CLK) disable iff (RST)
		cnt_ev && !dir_down && !one_shot && ACC == hi_lim && !lim_fix &&
		!pld_ev && !ovf_chk |=> ACC == $past(lo_lim)) // R4
		else $error("continuous count did not wrap to low limit");
	AST_SHOT_HOLD: assert property (@(posedge SYS_CLK) disable iff (RST)
		cnt_ev && one_shot && dir_down && ACC == lo_lim && !lim_fix &&
		!pld_ev && !ovf_chk |=> $stable(ACC)) // R5
		else $error("single shot count left the limit");
	AST_RATE: assert property (@(posedge SYS_CLK) disable iff (RST)
		tb_end && ENABLED |=> RATE == $past(next_rate)) // R7
		else $error("rate register missed interval count");
	AST_LIM_REJ: assert property (@(posedge SYS_CLK) disable iff (RST)
		CFG_LIM_WR && !lim_ok |=> LIM_ERR && $stable(hi_lim) &&
		$stable(lo_lim)) // R10
		else $error("bad limit pair was not rejected");
	AST_LIM_FIX: assert property (@(posedge SYS_CLK) disable iff (RST)
		lim_fix |=> ACC == lo_lim) // R9
		else $error("accumulator not moved to new low limit");
	AST_PRELOAD: assert property (@(posedge SYS_CLK) disable iff (RST)
		pld_ev && !lim_fix |=> ACC == $past(preload)) // R18
		else $error("preload value not loaded");
	AST_CMP_TIME: assert property (@(posedge SYS_CLK) disable iff (RST)
		$changed(OUT_Q) && $past(ENABLED) && $past(CPU_RUN) |->
		$past(cmp_tick)) // R17
		else $error("output changed outside a compare tick");
	AST_FORCE_LOW: assert property (@(posedge SYS_CLK) disable iff (RST)
		!CPU_RUN && fail_mode == pcc_pkg::fail_force_low ##1 !CPU_RUN
		|-> !OUT_Q) // R21
		else $error("forced low fail mode left output on");
	AST_DIS_OFF: assert property (@(posedge SYS_CLK) disable iff (RST)
		!ENABLED |=> !OUT_Q) // R24
		else $error("disabled counter drove output on");
endmodule : pcc_top
`default_nettype wire

/* verification/pcc_field_mdl.sv */
// field-side model: count and preload pulse sources
`timescale 1ns/1ns
`default_nettype none
module pcc_field_mdl (
	// clock
	input  wire logic clk,
	// requests from the bench, held high for a steady train
	input  wire logic cnt_req,
	input  wire logic pld_req,
	// field lines
	output logic      cnt_o,
	output logic      pld_o
);
	int cc; // count pulse phase
	int pc; // preload pulse phase

	// period of 20 cycles, 10 high and 10 low, so every pulse outlasts
	// both filter settings and a held request gives a steady train
	always @(negedge clk) begin
		cc <= (cc > 1) ? cc - 1 : (cnt_req ? 20 : 0);
		pc <= (pc > 1) ? pc - 1 : (pld_req ? 20 : 0);
	end

	// lines are low whenever no pulse is in flight
	assign cnt_o = cc > 10;
	assign pld_o = pc > 10;
endmodule : pcc_field_mdl
`default_nettype wire

/* verification/pulse_counter_core_tb_top.sv */
// self-checking bench for the pulse counter core
`timescale 1ns/1ns
`default_nettype none
module pulse_counter_core_tb_top;
	logic              SYS_CLK, RST, CNT_IN, PLD_IN, CPU_RUN;
	logic              CFG_WR, CFG_LIM_WR;
	logic [15:0]       CFG_HI_LIM, CFG_LO_LIM;
	pcc_pkg::pcc_cnt_t ACC, RATE, STROBE_VAL;
	logic              OUT_Q, ENABLED, LIM_ERR;
	logic              cnt_req, pld_req; // pulse requests to the model
	logic [15:0]       seed;             // random source state
	int                err_total, compares, cyc;
	// bench copy of the configuration and the accumulator
	int en, dn, shot, flt, fm, tbms, on, off, pld, hi, lo, macc, stb;
	int ons[6]  = '{30, 60, 45, 200, 200, 60};
	int offs[6] = '{60, 30, 45, 150, 200, 200};
	int accs[5] = '{10, 30, 45, 60, 80};

	// design with short sim counts
	pcc_top #(.CMP_CYC(20), .MS_CYC(10), .HF_CYC(3), .LF_CYC(8)) u_dut (
		.SYS_CLK(SYS_CLK), .RST(RST), .CNT_IN(CNT_IN), .PLD_IN(PLD_IN),
		.CPU_RUN(CPU_RUN), .CFG_WR(CFG_WR), .CFG_EN(en[0]),
		.CFG_DIR_DOWN(dn[0]), .CFG_ONE_SHOT(shot[0]),
		.CFG_CNT_FILT_LOW(flt[0]), .CFG_PLD_STROBE(stb[0]),
		.CFG_PLD_FILT_LOW(flt[0]), .CFG_FAIL_MODE(2'(fm)),
		.CFG_TIMEBASE(16'(tbms)), .CFG_ON_PST(16'(on)),
		.CFG_OFF_PST(16'(off)), .CFG_PRELOAD(16'(pld)),
		.CFG_LIM_WR(CFG_LIM_WR), .CFG_HI_LIM(CFG_HI_LIM),
		.CFG_LO_LIM(CFG_LO_LIM), .ACC(ACC), .RATE(RATE),
		.STROBE_VAL(STROBE_VAL),
		.OUT_Q(OUT_Q), .ENABLED(ENABLED), .LIM_ERR(LIM_ERR));

	// field pulse source
	pcc_field_mdl u_field (.clk(SYS_CLK), .cnt_req(cnt_req),
		.pld_req(pld_req), .cnt_o(CNT_IN), .pld_o(PLD_IN));

	// 50 MHz clock
	initial begin
		SYS_CLK = 0;
		forever #10 SYS_CLK = ~SYS_CLK;
	end

	// hang guard
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 10000) begin
			err_total++;
			close_out();
		end
	end

	// verdict and end of run
	task close_out;
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// one comparison
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// shift register random source
	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// expected output from accumulator and presets
	function logic [15:0] out_m(input int a);
		if (on <= off)
			return 16'(a >= on && a <= off);
		return 16'(a < off || a > on);
	endfunction : out_m

	// write the general configuration as one pulse
	task cfg;
		CFG_WR = 1;
		@(negedge SYS_CLK);
		CFG_WR = 0;
		@(negedge SYS_CLK);
	endtask : cfg

	// write a limit pair, update the bench model, check result
	// both limits go together, so high stays above low at every step
	task lim(input int h, input int l);
		CFG_HI_LIM = 16'(h);
		CFG_LO_LIM = 16'(l);
		CFG_LIM_WR = 1;
		@(negedge SYS_CLK);
		CFG_LIM_WR = 0;
		@(negedge SYS_CLK);
		if (h > l) begin
			hi = h;
			lo = l;
			if (macc > hi || macc < lo)
				macc = lo;
		end
		chk("lim_err", 16'(h <= l), {15'h0, LIM_ERR});
		chk("acc", 16'(macc), ACC);
	endtask : lim

	// one field pulse: p=0 count, p=1 preload; waits past a compare tick
	task pulse(input int p);
		if (p)
			pld_req <= 1;
		else
			cnt_req <= 1;
		@(negedge SYS_CLK);
		pld_req <= 0;
		cnt_req <= 0;
		repeat (45) @(negedge SYS_CLK);
		if (en && p && !stb)
			macc = (pld > hi) ? (shot ? hi : lo) : pld;
		else if (en && !p && !dn)
			macc = (macc >= hi) ? (shot ? macc : lo) : macc + 1;
		else if (en && !p)
			macc = (macc <= lo) ? (shot ? lo : hi) : macc - 1;
		chk("acc", 16'(macc), ACC);
	endtask : pulse

	// main sequence
	initial begin
		{RST, CPU_RUN, CFG_WR, CFG_LIM_WR, cnt_req, pld_req} = 6'h30;
		{CFG_HI_LIM, CFG_LO_LIM} = 32'h0;
		{en, dn, shot, flt, fm, on, off, pld, lo, macc} = '0;
		stb = 0;
		{tbms, hi, on} = {32'd1000, 32'd32767, 32'd32767};
		seed = 16'h8a30;
		repeat (4) @(negedge SYS_CLK);
		RST = 0;
		// disabled: count ignored, output low
		pulse(0);
		chk("out", 16'h0000, {15'h0, OUT_Q});
		chk("enabled", 16'h0000, {15'h0, ENABLED});
		$display("test disabled done");
		// enable, count up through the high limit
		en = 1;
		cfg();
		chk("enabled", 16'h0001, {15'h0, ENABLED});
		lim(3, 0);
		for (int i = 0; i < 5; i++) pulse(0);
		// slow filter, count down through the low limit
		flt = 1;
		dn = 1;
		cfg();
		for (int i = 0; i < 3; i++) pulse(0);
		$display("test wrap done");
		// single shot holds at the limit, reversal moves it off
		{flt, dn, shot, pld} = {32'd0, 32'd0, 32'd1, 32'd2};
		cfg();
		for (int i = 0; i < 3; i++) pulse(i == 0);
		dn = 1;
		cfg();
		pulse(0);
		// strobe mode captures the accumulator, slow filter request ignored
		{stb, flt} = {32'd1, 32'd1};
		cfg();
		pulse(1);
		chk("strobe", 16'(macc), STROBE_VAL);
		$display("test shot done");
		// bad pair refused, old limits still wrap, stray value forced low
		{dn, shot, pld, stb, flt} = {32'd0, 32'd0, 32'd3, 32'd0, 32'd0};
		cfg();
		pulse(1);
		lim(5, 5);
		pulse(0);
		lim(100, 50);
		lim(100, 0);
		$display("test limits done");
		// random preloads, then above and below the limits
		repeat (4) begin
			seed = lfsr(seed);
			pld = seed % 101;
			cfg();
			pulse(1);
		end
		for (int s = 0; s < 2; s++) begin
			{shot, pld} = {s, 32'd150};
			cfg();
			pulse(1);
		end
		{shot, pld} = {32'd0, -32'sd20};
		cfg();
		pulse(1);
		pulse(0);
		dn = 1;
		cfg();
		pulse(0);
		$display("test preload done");
		// steady train, short timebase raised to the minimum
		{dn, tbms} = {32'd0, 32'd5};
		cfg();
		cnt_req <= 1;
		repeat (300) @(negedge SYS_CLK);
		chk("rate", 16'h0005, RATE);
		dn = 1;
		cfg();
		repeat (300) @(negedge SYS_CLK);
		chk("rate", 16'hfffb, RATE);
		cnt_req <= 0;
		repeat (25) @(negedge SYS_CLK);
		$display("test rate done");
		// preset table swept by preload
		for (int k = 0; k < 6; k++) for (int j = 0; j < 5; j++) begin
			{on, off, pld} = {ons[k], offs[k], accs[j]};
			cfg();
			pulse(1);
			chk("out", out_m(pld), {15'h0, OUT_Q});
		end
		$display("test presets done");
		// host stop in each fail mode, then resume
		for (int m = 0; m < 3; m++) begin
			{on, off, pld, fm, dn} = {32'd45, 32'd60, 32'd45, m, 32'd1};
			cfg();
			pulse(1);
			CPU_RUN = 0;
			repeat (45) @(negedge SYS_CLK);
			chk("out", 16'(m != 1), {15'h0, OUT_Q});
			pulse(0);
			chk("out", 16'(m == 2), {15'h0, OUT_Q});
			CPU_RUN = 1;
			repeat (45) @(negedge SYS_CLK);
			chk("out", 16'h0000, {15'h0, OUT_Q});
		end
		$display("test fail modes done");
		close_out();
	end
endmodule : pulse_counter_core_tb_top
`default_nettype wire
